/* core/uart_fc_map.svh */
// slot numbers, trigger levels, reset value and timing counts of the flow block
`ifndef UART_FC_MAP_SVH
`define UART_FC_MAP_SVH

// ----------------------------------------------------------------
// receive trigger levels and hysteresis thresholds
// ----------------------------------------------------------------
`define TRIG_LVL_8          7'h08
`define TRIG_LVL_16         7'h10
`define TRIG_LVL_56         7'h38
`define TRIG_LVL_60         7'h3c
`define LVL_ZERO            7'h00

// ----------------------------------------------------------------
// flow character slots and reset value
// ----------------------------------------------------------------
`define SLOT_STOP_FIRST     2'h0
`define SLOT_STOP_SECOND    2'h1
`define SLOT_RESUME_FIRST   2'h2
`define SLOT_RESUME_SECOND  2'h3
`define FLOW_CHAR_RESET     8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TICKS_PER_BIT       16
`define CHAR_BITS_DEFAULT   10
`define GUARD_CHARS         2
`define IR10_PULSE_TICKS    4'h3
`define IR11_PULSE_TICKS    4'h4

`endif

/* core/uart_fc_pkg.sv */
// types shared by the flow-control, multidrop and infrared block
package uart_fc_pkg;

	typedef enum logic [2:0] {
		FC_IDLE,
		FC_GUARD,
		FC_STOP_A,
		FC_STOP_B,
		FC_HALTED,
		FC_RES_A,
		FC_RES_B
	} fc_state_t;

	typedef enum logic [1:0] {
		PEND_NONE,
		PEND_STOP,
		PEND_RESUME
	} pend_t;

endpackage

/* core/uart_flow_ctrl.sv */
// uart flow control, multidrop and infrared logic
// What this block does
// R1 - auto rts on feature bit 6 once host asserts rts
// R2 - rts rise sets status bit 5, interrupt if enabled
// R3 - auto rts goes high at levels 16,56,60,60
// R4 - rts returns low at levels 0,8,16,56
// R5 - interrupt at receive trigger level under auto rts
// R6 - auto cts on feature bit 7 gates transmitter
// R7 - cts rise sets status bit 5, interrupt if enabled
// R8 - transmitter halts after current char, resumes on cts low
// R9 - software flow matches one or two chars to stop chars
// R10 - stop match sets flag and interrupt; resume match clears
// R11 - reset clears all four flow chars
// R12 - matched flow chars never enter the fifo
// R13 - fifo at trigger sends stop chars two char times later
// R14 - resume chars sent at next lower level
// R15 - special detect on bit 5 matches second stop char, keeps it
// R16 - compares use word-length bits, bit 0 is lsb
// R17 - normal multidrop: multidrop bit set, special detect clear
// R18 - disabled receiver drops data; address flags parity, enters fifo
// R19 - auto address: match enables receiver, enters fifo
// R20 - later mismatched address disables receiver, dropped
// R21 - infrared 1.0 sends 3/16 bit pulse per zero bit
// R22 - infrared 1.1 sends quarter bit pulse per zero bit
// R23 - infrared rx idles low; a pulse becomes a received bit
`timescale 1ns/100ps
`default_nettype none
`include "uart_fc_map.svh"

module uart_flow_ctrl #(
	parameter int CHAR_BITS = `CHAR_BITS_DEFAULT
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       efr_enhanced,
	input  wire logic       efr_special,
	input  wire logic       efr_auto_rts,
	input  wire logic       efr_auto_cts,
	input  wire logic       ier_stop_ie,
	input  wire logic       ier_rts_ie,
	input  wire logic       ier_cts_ie,
	input  wire logic       mcr_rts,
	input  wire logic       mcr_ir_en,
	input  wire logic       msr_multidrop,
	input  wire logic       msr_ir11,
	input  wire logic [1:0] line_word_len,
	input  wire logic [1:0] trig_sel,
	input  wire logic       sw_rx_flow_en,
	input  wire logic       sw_tx_flow_en,
	input  wire logic       sw_flow_double,
	input  wire logic       rx_sw_enable,
	input  wire logic       char_wr,
	input  wire logic [1:0] char_sel,
	input  wire logic [7:0] char_wdata,
	input  wire logic       status_clr,
	input  wire logic [6:0] rx_level,
	input  wire logic       rx_char_valid,
	input  wire logic [7:0] rx_char_data,
	input  wire logic       rx_char_parity,
	input  wire logic       bit_tick,
	input  wire logic       tx_busy,
	input  wire logic       fc_ready,
	input  wire logic       tx_serial,
	input  wire logic [3:0] tx_phase,
	input  wire logic       ir_rx_pin,
	input  wire logic       rx_pin,
	input  wire logic       cts_n,
	output logic            rts_n,
	output logic            tx_allow,
	output logic            fifo_push,
	output logic [7:0]      fifo_data,
	output logic            fifo_perr,
	output logic            fc_valid,
	output logic [7:0]      fc_char,
	output logic            rts_flag,
	output logic            cts_flag,
	output logic            stop_flag,
	output logic            special_flag,
	output logic            line_status_irq,
	output logic            auto_rx_enabled,
	output logic            irq,
	output logic            tx_pin,
	output logic            rx_serial
);

	// ----------------------------------------------------------------
	// thresholds
	// ----------------------------------------------------------------
	localparam int GUARD_TICKS = `GUARD_CHARS * CHAR_BITS * `TICKS_PER_BIT;
	localparam logic [11:0] GUARD_LAST = 12'(GUARD_TICKS - 1);

	logic [6:0] lvl_trig;
	logic [6:0] lvl_hi;
	logic [6:0] lvl_lo;
	logic [7:0] len_mask;

	always_comb begin
		unique case (trig_sel)
			2'h0: {lvl_trig, lvl_hi, lvl_lo} =
				{`TRIG_LVL_8, `TRIG_LVL_16, `LVL_ZERO};
			2'h1: {lvl_trig, lvl_hi, lvl_lo} =
				{`TRIG_LVL_16, `TRIG_LVL_56, `TRIG_LVL_8};
			2'h2: {lvl_trig, lvl_hi, lvl_lo} =
				{`TRIG_LVL_56, `TRIG_LVL_60, `TRIG_LVL_16};
			2'h3: {lvl_trig, lvl_hi, lvl_lo} =
				{`TRIG_LVL_60, `TRIG_LVL_60, `TRIG_LVL_56};
		endcase
		unique case (line_word_len)   // [R16]
			2'h0: len_mask = 8'h1f;
			2'h1: len_mask = 8'h3f;
			2'h2: len_mask = 8'h7f;
			2'h3: len_mask = 8'hff;
		endcase
	end

	// ----------------------------------------------------------------
	// flow characters
	// ----------------------------------------------------------------
	logic [7:0] char_reg [4];
	logic [7:0] char_next [4];

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			char_next[i] = char_reg[i];
		end
		if (char_wr) begin
			char_next[char_sel] = char_wdata;
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (sys_rst) begin
				char_reg[i] <= `FLOW_CHAR_RESET;   // [R11]
			end else begin
				char_reg[i] <= char_next[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// receive path
	// ----------------------------------------------------------------
	logic             halt_reg, halt_next;
	logic             rts_off_reg, rts_off_next;
	logic             rts_prev_reg, rts_prev_next;
	logic             cts_prev_reg, cts_prev_next;
	logic             tx_allow_reg, tx_allow_next;
	logic             auto_en_reg, auto_en_next;
	logic             push_reg, push_next;
	logic [7:0]       data_reg, data_next;
	logic             perr_reg, perr_next;
	logic             lsi_reg, lsi_next;
	logic             rtsf_reg, rtsf_next;
	logic             ctsf_reg, ctsf_next;
	logic             stopf_reg, stopf_next;
	logic             specf_reg, specf_next;
	uart_fc_pkg::pend_t pend_reg, pend_next;
	logic [7:0]       pend_char_reg, pend_char_next;
	logic             replay_reg, replay_next;
	logic [7:0]       replay_char_reg, replay_char_next;

	logic       multidrop;
	logic       auto_rts;
	logic       cv;
	logic [7:0] cd;
	logic       rts_pin;
	logic       set_stop;
	logic       set_res;

	function automatic logic same(input logic [7:0] a, input logic [7:0] b,
			input logic [7:0] m);
		same = ((a ^ b) & m) == 8'h00;   // [R16]
	endfunction

	always_comb begin
		multidrop = msr_multidrop & efr_enhanced;
		auto_rts  = efr_auto_rts & mcr_rts;   // [R1]
		cv        = rx_char_valid | replay_reg;
		cd        = replay_reg ? replay_char_reg : rx_char_data;
		halt_next        = halt_reg;
		rts_off_next     = rts_off_reg;
		auto_en_next     = auto_en_reg;
		push_next        = 1'b0;
		data_next        = data_reg;
		perr_next        = 1'b0;
		lsi_next         = 1'b0;
		pend_next        = pend_reg;
		pend_char_next   = pend_char_reg;
		replay_next      = 1'b0;
		replay_char_next = replay_char_reg;
		set_stop         = 1'b0;
		set_res          = 1'b0;
		specf_next       = specf_reg & ~status_clr;
		// rts hysteresis
		if (!auto_rts) begin
			rts_off_next = 1'b0;
		end else if (rx_level >= lvl_hi) begin
			rts_off_next = 1'b1;   // [R3]
		end else if (rx_level <= lvl_lo) begin
			rts_off_next = 1'b0;   // [R4]
		end
		if (cv && multidrop && !efr_special) begin
			// software decides on the address byte
			if (rx_char_parity || rx_sw_enable) begin   // [R17] [R18]
				push_next = 1'b1;
				data_next = cd;
				perr_next = rx_char_parity;
				lsi_next  = rx_char_parity;
			end
		end else if (cv && multidrop) begin
			if (rx_char_parity) begin
				if (same(cd, char_reg[`SLOT_STOP_SECOND], len_mask)) begin
					auto_en_next = 1'b1;   // [R19]
					push_next    = 1'b1;
					data_next    = cd;
					perr_next    = 1'b1;
					lsi_next     = 1'b1;
				end else begin
					auto_en_next = 1'b0;   // [R20]
				end
			end else if (auto_en_reg) begin
				push_next = 1'b1;
				data_next = cd;
			end
		end else if (cv) begin
			if (sw_rx_flow_en && pend_reg != uart_fc_pkg::PEND_NONE) begin
				pend_next = uart_fc_pkg::PEND_NONE;
				if (pend_reg == uart_fc_pkg::PEND_STOP &&
						same(cd, char_reg[`SLOT_STOP_SECOND], len_mask)) begin
					set_stop = 1'b1;   // [R9] [R12]
				end else if (pend_reg == uart_fc_pkg::PEND_RESUME &&
						same(cd, char_reg[`SLOT_RESUME_SECOND], len_mask)) begin
					set_res = 1'b1;   // [R12]
				end else begin
					// pair broken: release held char, look at this one again
					push_next        = 1'b1;
					data_next        = pend_char_reg;
					replay_next      = 1'b1;
					replay_char_next = cd;
				end
			end else if (sw_rx_flow_en &&
					same(cd, char_reg[`SLOT_STOP_FIRST], len_mask)) begin
				if (sw_flow_double) begin
					pend_next      = uart_fc_pkg::PEND_STOP;   // [R9]
					pend_char_next = cd;
				end else begin
					set_stop = 1'b1;   // [R12]
				end
			end else if (sw_rx_flow_en &&
					same(cd, char_reg[`SLOT_RESUME_FIRST], len_mask)) begin
				if (sw_flow_double) begin
					pend_next      = uart_fc_pkg::PEND_RESUME;
					pend_char_next = cd;
				end else begin
					set_res = 1'b1;   // [R12]
				end
			end else begin
				push_next = 1'b1;
				data_next = cd;
				if (efr_special &&
						same(cd, char_reg[`SLOT_STOP_SECOND], len_mask)) begin
					specf_next = 1'b1;   // [R15]
				end
			end
		end
		if (!sw_rx_flow_en) begin
			halt_next = 1'b0;
			pend_next = uart_fc_pkg::PEND_NONE;
		end else if (set_stop) begin
			halt_next = 1'b1;   // [R9]
		end else if (set_res) begin
			halt_next = 1'b0;   // [R10]
		end
		// resume clears the stop flag in hardware; a new stop wins
		stopf_next = set_stop | (stopf_reg & ~status_clr & ~set_res);   // [R10]
		rts_pin = ~mcr_rts | (auto_rts & rts_off_reg);
		rts_prev_next = rts_pin;
		cts_prev_next = cts_n;
		rtsf_next = (rts_pin & ~rts_prev_reg) | (rtsf_reg & ~status_clr);   // [R2]
		ctsf_next = (cts_n & ~cts_prev_reg) | (ctsf_reg & ~status_clr);   // [R7]
		// gating only moves between characters, so a frame is never cut
		tx_allow_next = tx_busy ? tx_allow_reg
			: ~(efr_auto_cts & cts_n) & ~halt_reg;   // [R6] [R8]
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			halt_reg        <= 1'b0;
			rts_off_reg     <= 1'b0;
			rts_prev_reg    <= 1'b1;
			cts_prev_reg    <= 1'b1;
			tx_allow_reg    <= 1'b1;
			auto_en_reg     <= 1'b0;
			push_reg        <= 1'b0;
			data_reg        <= 8'h00;
			perr_reg        <= 1'b0;
			lsi_reg         <= 1'b0;
			rtsf_reg        <= 1'b0;
			ctsf_reg        <= 1'b0;
			stopf_reg       <= 1'b0;
			specf_reg       <= 1'b0;
			pend_reg        <= uart_fc_pkg::PEND_NONE;
			pend_char_reg   <= 8'h00;
			replay_reg      <= 1'b0;
			replay_char_reg <= 8'h00;
		end else begin
			halt_reg        <= halt_next;
			rts_off_reg     <= rts_off_next;
			rts_prev_reg    <= rts_prev_next;
			cts_prev_reg    <= cts_prev_next;
			tx_allow_reg    <= tx_allow_next;
			auto_en_reg     <= auto_en_next;
			push_reg        <= push_next;
			data_reg        <= data_next;
			perr_reg        <= perr_next;
			lsi_reg         <= lsi_next;
			rtsf_reg        <= rtsf_next;
			ctsf_reg        <= ctsf_next;
			stopf_reg       <= stopf_next;
			specf_reg       <= specf_next;
			pend_reg        <= pend_next;
			pend_char_reg   <= pend_char_next;
			replay_reg      <= replay_next;
			replay_char_reg <= replay_char_next;
		end
	end

	// ----------------------------------------------------------------
	// automatic stop and resume sending
	// ----------------------------------------------------------------
	uart_fc_pkg::fc_state_t fc_reg, fc_next;
	logic [11:0]            guard_reg, guard_next;
	logic [7:0]             fc_char_reg, fc_char_next;

	always_comb begin
		fc_next      = fc_reg;
		guard_next   = guard_reg;
		fc_char_next = fc_char_reg;
		unique case (fc_reg)
			uart_fc_pkg::FC_IDLE: begin
				guard_next = 12'h000;
				if (sw_tx_flow_en && rx_level >= lvl_trig) begin
					fc_next = uart_fc_pkg::FC_GUARD;
				end
			end
			uart_fc_pkg::FC_GUARD: begin
				if (bit_tick) begin
					if (guard_reg == GUARD_LAST) begin
						fc_next      = uart_fc_pkg::FC_STOP_A;   // [R13]
						fc_char_next = char_reg[`SLOT_STOP_FIRST];
					end else begin
						guard_next = guard_reg + 12'h001;
					end
				end
			end
			uart_fc_pkg::FC_STOP_A: begin
				if (fc_ready) begin
					fc_next      = sw_flow_double ? uart_fc_pkg::FC_STOP_B
						: uart_fc_pkg::FC_HALTED;
					fc_char_next = char_reg[`SLOT_STOP_SECOND];
				end
			end
			uart_fc_pkg::FC_STOP_B: begin
				if (fc_ready) begin
					fc_next = uart_fc_pkg::FC_HALTED;
				end
			end
			uart_fc_pkg::FC_HALTED: begin
				if (rx_level <= lvl_lo) begin
					fc_next      = uart_fc_pkg::FC_RES_A;   // [R14]
					fc_char_next = char_reg[`SLOT_RESUME_FIRST];
				end
			end
			uart_fc_pkg::FC_RES_A: begin
				if (fc_ready) begin
					fc_next      = sw_flow_double ? uart_fc_pkg::FC_RES_B
						: uart_fc_pkg::FC_IDLE;
					fc_char_next = char_reg[`SLOT_RESUME_SECOND];
				end
			end
			uart_fc_pkg::FC_RES_B: begin
				if (fc_ready) begin
					fc_next = uart_fc_pkg::FC_IDLE;
				end
			end
			default: fc_next = uart_fc_pkg::FC_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fc_reg      <= uart_fc_pkg::FC_IDLE;
			guard_reg   <= 12'h000;
			fc_char_reg <= 8'h00;
		end else begin
			fc_reg      <= fc_next;
			guard_reg   <= guard_next;
			fc_char_reg <= fc_char_next;
		end
	end

	// ----------------------------------------------------------------
	// infrared encoder and decoder
	// ----------------------------------------------------------------
	logic       tx_pin_reg, tx_pin_next;
	logic       rxs_reg, rxs_next;
	logic       ir_prev_reg, ir_prev_next;
	logic [3:0] stretch_reg, stretch_next;
	logic       stretch_on_reg, stretch_on_next;
	logic [3:0] ir_width;

	always_comb begin
		ir_width = (msr_ir11 & efr_enhanced) ? `IR11_PULSE_TICKS
			: `IR10_PULSE_TICKS;
		tx_pin_next = mcr_ir_en ? ~tx_serial & (tx_phase < ir_width)
			: tx_serial;   // [R21] [R22]
		ir_prev_next    = ir_rx_pin;
		stretch_next    = stretch_reg;
		stretch_on_next = stretch_on_reg;
		if (ir_rx_pin && !ir_prev_reg) begin
			stretch_on_next = 1'b1;   // [R23]
			stretch_next    = 4'h0;
		end else if (stretch_on_reg && bit_tick) begin
			stretch_next = stretch_reg + 4'h1;
			if (stretch_reg == 4'hf) begin
				stretch_on_next = 1'b0;
			end
		end
		// a pulse is held for one bit so the sampler sees a full zero bit
		rxs_next = mcr_ir_en ? ~stretch_on_reg : rx_pin;   // [R23]
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_pin_reg     <= 1'b1;
			rxs_reg        <= 1'b1;
			ir_prev_reg    <= 1'b0;
			stretch_reg    <= 4'h0;
			stretch_on_reg <= 1'b0;
		end else begin
			tx_pin_reg     <= tx_pin_next;
			rxs_reg        <= rxs_next;
			ir_prev_reg    <= ir_prev_next;
			stretch_reg    <= stretch_next;
			stretch_on_reg <= stretch_on_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rts_n           = rts_pin;   // [R1]
	assign tx_allow        = tx_allow_reg;
	assign fifo_push       = push_reg;
	assign fifo_data       = data_reg;
	assign fifo_perr       = perr_reg;
	assign fc_valid        = !(fc_reg inside {uart_fc_pkg::FC_IDLE,
		uart_fc_pkg::FC_GUARD, uart_fc_pkg::FC_HALTED});
	assign fc_char         = fc_char_reg;
	assign rts_flag        = rtsf_reg;
	assign cts_flag        = ctsf_reg;
	assign stop_flag       = stopf_reg;
	assign special_flag    = specf_reg;
	assign line_status_irq = lsi_reg;
	assign auto_rx_enabled = auto_en_reg;
	assign tx_pin          = tx_pin_reg;
	assign rx_serial       = rxs_reg;
	assign irq = (rtsf_reg & ier_rts_ie & efr_enhanced)   // [R2]
		| (ctsf_reg & ier_cts_ie & efr_enhanced)   // [R7]
		| (stopf_reg & ier_stop_ie)   // [R10]
		| (auto_rts & (rx_level >= lvl_trig))   // [R5]
		| lsi_reg;

endmodule // uart_flow_ctrl
`default_nettype wire

/* verif/serial_peer.sv */
// remote serial peer: received chars, handshake pin, flow char sink
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
	input  wire logic       clk,
	input  wire logic       slow,
	input  wire logic       fc_valid,
	input  wire logic [7:0] fc_char,
	output logic            fc_ready,
	output logic            rx_char_valid,
	output logic [7:0]      rx_char_data,
	output logic            rx_char_parity,
	output logic            cts_n,
	output logic            ir_rx_pin
);
	logic [7:0] seen[$];

	initial begin
		fc_ready = 1'b0;
		rx_char_valid = 1'b0;
		rx_char_data = 8'h00;
		rx_char_parity = 1'b0;
		cts_n = 1'b0;
		ir_rx_pin = 1'b0;
	end

	// slow holds off fc_ready
	always @(posedge clk) begin
		if (fc_valid && fc_ready)
			seen.push_back(fc_char);
		fc_ready <= fc_valid && !fc_ready && !slow;
	end

	task automatic step;
		@(posedge clk);
		#1;
	endtask

	task automatic send(input logic [7:0] d, input logic p);
		step();
		rx_char_valid = 1'b1;
		rx_char_data = d;
		rx_char_parity = p;
		step();
		rx_char_valid = 1'b0;
		// released bus shows no stale byte
		rx_char_data = ~d;
		rx_char_parity = ~p;
	endtask

	task automatic set_cts(input logic v);
		step();
		cts_n = v;
	endtask

	task automatic ir_pulse;
		step();
		ir_rx_pin = 1'b1;
		step();
		ir_rx_pin = 1'b0;
	endtask
endmodule // serial_peer
`default_nettype wire

/* verif/test_uart_flow_ctrl.sv */
// bench for the flow, multidrop and infrared block
`timescale 1ns/100ps
`default_nettype none
module test_uart_flow_ctrl;
	// ------------------------------------------------------------
	// signals and instances
	// ------------------------------------------------------------
	logic clk = 1'b0, sys_rst = 1'b1, slow = 1'b0, bit_tick = 1'b0;
	logic efr_enhanced = 1'b0, efr_special = 1'b0, efr_auto_rts = 1'b0;
	logic efr_auto_cts = 1'b0, ier_stop_ie = 1'b0, ier_rts_ie = 1'b0;
	logic ier_cts_ie = 1'b0, mcr_rts = 1'b0, mcr_ir_en = 1'b0;
	logic msr_multidrop = 1'b0, msr_ir11 = 1'b0, sw_rx_flow_en = 1'b0;
	logic sw_tx_flow_en = 1'b0, sw_flow_double = 1'b0, rx_sw_enable = 1'b0;
	logic char_wr = 1'b0, status_clr = 1'b0, tx_busy = 1'b0;
	logic tx_serial = 1'b1, rx_pin = 1'b1;
	logic [1:0] line_word_len = 2'h3, trig_sel = 2'h0, char_sel = 2'h0;
	logic [7:0] char_wdata = 8'h00;
	logic [6:0] rx_level = 7'h00;
	logic [3:0] tx_phase = 4'h0;
	logic fc_ready, rx_char_valid, rx_char_parity, cts_n, ir_rx_pin;
	logic [7:0] rx_char_data, fifo_data, fc_char;
	logic rts_n, tx_allow, fifo_push, fifo_perr, fc_valid, rts_flag;
	logic cts_flag, stop_flag, special_flag, line_status_irq;
	logic auto_rx_enabled, irq, tx_pin, rx_serial;
	int fails = 0, num_checks = 0;

	// guard wait of 64 ticks
	uart_flow_ctrl #(.CHAR_BITS(2)) dut_u (.*);
	serial_peer peer_u (.*);

	always #20 clk = ~clk;
	always @(posedge clk) bit_tick <= ~bit_tick;

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk_bit(input string s, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %b seen %b", s, e, g);
		end
	endtask
	task automatic chk_byte(input string s, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wc(input logic [1:0] s, input logic [7:0] d);
		char_sel = s;
		char_wdata = d;
		char_wr = 1'b1;
		tk(1);
		char_wr = 1'b0;
	endtask
	task automatic clr;
		status_clr = 1'b1;
		tk(1);
		status_clr = 1'b0;
		tk(1);
	endtask
	task automatic rx(input logic [7:0] d, input logic p, input logic e);
		peer_u.send(d, p);
		chk_bit("fifo_push", e, fifo_push);
		if (e)
			chk_byte("fifo_data", d, fifo_data);
		if (e && msr_multidrop) begin
			chk_bit("fifo_perr", p, fifo_perr);
			chk_bit("line_status_irq", p, line_status_irq);
		end
		tk(2);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_flow;
		sw_rx_flow_en = 1'b1;
		ier_stop_ie = 1'b1;
		rx(8'h00, 1'b0, 1'b0);
		chk_bit("stop_flag", 1'b1, stop_flag);
		wc(2'h0, 8'h13);
		wc(2'h2, 8'h11);
		rx(8'h11, 1'b0, 1'b0);
		chk_bit("stop_flag", 1'b0, stop_flag);
		line_word_len = 2'h0;
		rx(8'hf3, 1'b0, 1'b0);
		chk_bit("irq", 1'b1, irq);
		chk_bit("tx_allow", 1'b0, tx_allow);
		rx(8'h31, 1'b0, 1'b0);
		chk_bit("tx_allow", 1'b1, tx_allow);
		line_word_len = 2'h3;
		rx(8'hf3, 1'b0, 1'b1);
		sw_flow_double = 1'b1;
		rx(8'h13, 1'b0, 1'b0);
		rx(8'h00, 1'b0, 1'b0);
		chk_bit("stop_flag", 1'b1, stop_flag);
		sw_flow_double = 1'b0;
		sw_rx_flow_en = 1'b0;
		ier_stop_ie = 1'b0;
	endtask

	task automatic t_rts;
		logic [6:0] hi[4] = '{7'h10, 7'h38, 7'h3c, 7'h3c};
		logic [6:0] lo[4] = '{7'h00, 7'h08, 7'h10, 7'h38};
		efr_enhanced = 1'b1;
		ier_rts_ie = 1'b1;
		efr_auto_rts = 1'b1;
		tk(2);
		chk_bit("rts_n", 1'b1, rts_n);
		mcr_rts = 1'b1;
		for (int i = 0; i < 4; i++) begin
			trig_sel = 2'(i);
			rx_level = hi[i] - 7'h01;
			tk(2);
			chk_bit("rts_n", 1'b0, rts_n);
			if (i == 0)
				chk_bit("irq", 1'b1, irq);
			rx_level = hi[i];
			tk(2);
			chk_bit("rts_n", 1'b1, rts_n);
			rx_level = lo[i] + 7'h01;
			tk(2);
			chk_bit("rts_n", 1'b1, rts_n);
			rx_level = lo[i];
			tk(2);
			chk_bit("rts_n", 1'b0, rts_n);
		end
		chk_bit("rts_flag", 1'b1, rts_flag);
		efr_auto_rts = 1'b0;
		clr();
	endtask

	task automatic t_cts;
		efr_auto_cts = 1'b1;
		ier_cts_ie = 1'b1;
		tx_busy = 1'b1;
		peer_u.set_cts(1'b1);
		tk(2);
		chk_bit("tx_allow", 1'b1, tx_allow);
		chk_bit("cts_flag", 1'b1, cts_flag);
		tx_busy = 1'b0;
		tk(2);
		chk_bit("tx_allow", 1'b0, tx_allow);
		peer_u.set_cts(1'b0);
		tk(2);
		chk_bit("tx_allow", 1'b1, tx_allow);
		efr_auto_cts = 1'b0;
	endtask

	task automatic t_special;
		efr_special = 1'b1;
		wc(2'h1, 8'h5a);
		rx(8'h5a, 1'b0, 1'b1);
		chk_bit("special_flag", 1'b1, special_flag);
		clr();
		chk_bit("special_flag", 1'b0, special_flag);
		efr_special = 1'b0;
	endtask

	// parity bit arrives as rx_char_parity
	task automatic t_mdrop;
		msr_multidrop = 1'b1;
		rx(8'h22, 1'b0, 1'b0);
		rx(8'h33, 1'b1, 1'b1);
		rx_sw_enable = 1'b1;
		rx(8'h44, 1'b0, 1'b1);
		rx_sw_enable = 1'b0;
		efr_special = 1'b1;
		wc(2'h1, 8'ha5);
		rx(8'h44, 1'b0, 1'b0);
		rx(8'h66, 1'b1, 1'b0);
		rx(8'ha5, 1'b1, 1'b1);
		chk_bit("auto_rx_enabled", 1'b1, auto_rx_enabled);
		rx(8'h77, 1'b0, 1'b1);
		rx(8'h66, 1'b1, 1'b0);
		chk_bit("auto_rx_enabled", 1'b0, auto_rx_enabled);
		rx(8'h55, 1'b0, 1'b0);
		msr_multidrop = 1'b0;
		efr_special = 1'b0;
	endtask

	task automatic t_fc;
		slow = 1'b1;
		trig_sel = 2'h0;
		sw_tx_flow_en = 1'b1;
		rx_level = 7'h08;
		tk(100);
		chk_bit("fc_valid", 1'b0, fc_valid);
		for (int i = 0; i < 60 && fc_valid !== 1'b1; i++)
			tk(1);
		chk_byte("fc_char", 8'h13, fc_char);
		tk(5);
		chk_bit("fc_valid", 1'b1, fc_valid);
		slow = 1'b0;
		rx_level = 7'h01;
		tk(20);
		chk_byte("sent", 8'h13, peer_u.seen[0]);
		chk_bit("resume early", 1'b0, peer_u.seen.size() > 1);
		rx_level = 7'h00;
		for (int i = 0; i < 50 && peer_u.seen.size() < 2; i++)
			tk(1);
		chk_byte("sent", 8'h11, peer_u.seen[1]);
		sw_tx_flow_en = 1'b0;
	endtask

	task automatic t_ir;
		mcr_ir_en = 1'b1;
		tx_serial = 1'b0;
		for (int m = 0; m < 2; m++) begin
			msr_ir11 = m[0];
			for (int p = 0; p < 16; p++) begin
				tx_phase = 4'(p);
				tk(1);
				chk_bit("tx_pin", p < 3 + m, tx_pin);
			end
		end
		tx_serial = 1'b1;
		tk(2);
		chk_bit("rx_serial", 1'b1, rx_serial);
		peer_u.ir_pulse();
		tk(2);
		chk_bit("rx_serial", 1'b0, rx_serial);
		tk(40);
		chk_bit("rx_serial", 1'b1, rx_serial);
		mcr_ir_en = 1'b0;
	endtask

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// about 360 cycles needed
	initial begin
		#400000;
		fails++;
		close_out();
	end

	initial begin
		tk(3);
		sys_rst = 1'b0;
		t_flow();
		t_rts();
		t_cts();
		t_special();
		t_mdrop();
		t_fc();
		t_ir();
		close_out();
	end
endmodule // test_uart_flow_ctrl

bind uart_flow_ctrl uart_flow_ctrl_asserts chk_u (.*);
`default_nettype wire

/* verif/uart_flow_ctrl_asserts.sv */
// port checks of the flow, multidrop and infrared block
`timescale 1ns/100ps
`default_nettype none
module uart_flow_ctrl_asserts (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       efr_enhanced,
	input wire logic       efr_auto_rts,
	input wire logic       efr_auto_cts,
	input wire logic       ier_stop_ie,
	input wire logic       ier_rts_ie,
	input wire logic       ier_cts_ie,
	input wire logic       mcr_rts,
	input wire logic       mcr_ir_en,
	input wire logic       msr_ir11,
	input wire logic [6:0] rx_level,
	input wire logic       rx_char_valid,
	input wire logic       tx_busy,
	input wire logic       tx_serial,
	input wire logic [3:0] tx_phase,
	input wire logic       cts_n,
	input wire logic       rts_n,
	input wire logic       tx_allow,
	input wire logic       fifo_push,
	input wire logic       rts_flag,
	input wire logic       cts_flag,
	input wire logic       stop_flag,
	input wire logic       irq,
	input wire logic       tx_pin
);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	chk_rts_manual: assert property (
		!efr_auto_rts |-> rts_n == !mcr_rts)
		else $error("rts_n ignores host request");
	chk_rts_full: assert property (
		(efr_auto_rts && mcr_rts && rx_level >= 7'h3c) [*2] |-> rts_n)
		else $error("rts_n low with fifo at top level");
	chk_rts_drain: assert property (
		(efr_auto_rts && mcr_rts && rx_level == 7'h00) [*2] |-> !rts_n)
		else $error("rts_n high with empty fifo");
	chk_rts_edge: assert property (
		$rose(rts_n) && efr_enhanced && ier_rts_ie |=> rts_flag)
		else $error("rts rise not flagged");
	chk_cts_edge: assert property (
		$rose(cts_n) && efr_enhanced && ier_cts_ie |=> cts_flag)
		else $error("cts rise not flagged");
	chk_cts_gate: assert property (
		efr_auto_cts && cts_n && !tx_busy |=> !tx_allow)
		else $error("transmitter allowed with cts off");
	chk_allow_hold: assert property (
		tx_busy |=> $stable(tx_allow))
		else $error("tx_allow moved mid-character");
	chk_stop_irq: assert property (
		stop_flag && ier_stop_ie |-> irq)
		else $error("stop flag without interrupt");
	chk_ir10_pulse: assert property (
		mcr_ir_en && !(efr_enhanced && msr_ir11) |=>
		tx_pin == (!$past(tx_serial) && $past(tx_phase) < 4'h3))
		else $error("ir 1.0 pulse width wrong");
	chk_ir11_pulse: assert property (
		mcr_ir_en && efr_enhanced && msr_ir11 |=>
		tx_pin == (!$past(tx_serial) && $past(tx_phase) < 4'h4))
		else $error("ir 1.1 pulse width wrong");
	chk_push_cause: assert property (
		fifo_push |-> $past(rx_char_valid) || $past(rx_char_valid, 2))
		else $error("push without received char");
endmodule // uart_flow_ctrl_asserts
`default_nettype wire
